// File: hw/scd_pkg.sv
// shared constants and types for the sensor command decoder
package scd_pkg;
    localparam logic [7:0] SCD_CMD_GO_NORMAL = 8'ha8;
    localparam logic [7:0] SCD_CMD_GO_COMMAND = 8'ha9;
    localparam logic [7:0] SCD_CMD_COMMIT_CSUM = 8'haa;
    localparam logic [7:0] SCD_CMD_FULL_MEAS = 8'hac;
    localparam logic [4:0] SCD_CMD_RAW_TOP = 5'h14;
    localparam logic [3:0] SCD_CMD_NOP_NIBBLE = 4'hf;

    localparam logic [1:0] SCD_MODE_NORMAL = 2'h0;
    localparam logic [1:0] SCD_MODE_COMMAND = 2'h1;

    localparam int SCD_ST_POWER = 6;
    localparam int SCD_ST_BUSY = 5;
    localparam int SCD_ST_MODE_LO = 3;
    localparam int SCD_ST_MODE_HI = 4;
    localparam int SCD_TEMP_KEEP_MSB = 12;
    localparam int SCD_TEMP_DROP_LSB = 13;

    localparam logic [7:0] SCD_STATUS_RST = 8'h40;
    localparam logic [15:0] SCD_WORD_RST = 16'h0000;

    typedef enum logic [1:0] {
        SCD_STEP_AZ_BRIDGE = 2'h0,
        SCD_STEP_BRIDGE = 2'h1,
        SCD_STEP_AZ_TEMP = 2'h2,
        SCD_STEP_TEMP = 2'h3
    } scd_step_t;

    typedef enum logic [3:0] {
        SCD_IDLE = 4'h1,
        SCD_CONV = 4'h2,
        SCD_CALC = 4'h4,
        SCD_CSUM = 4'h8
    } scd_state_t;

    typedef struct packed {
        scd_step_t step;
        logic [15:0] setup;
    } scd_conv_req_t;

    typedef struct packed {
        logic [15:0] az_bridge;
        logic [15:0] bridge;
        logic [15:0] az_temp;
        logic [15:0] temp;
    } scd_calc_req_t;

    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
    } scd_result_t;
endpackage : scd_pkg

// File: hw/scd_decoder.sv
// command decoder and measurement sequencer of the sensor conditioner
`timescale 1ns/1ps

// Overview of operation
// - A8 in command mode switches to normal mode; ignored in normal mode.
// - A9 as the first command after reset switches to command mode; refused otherwise.
// - AA in command mode starts checksum commit if page has none yet.
// - AC runs autozero bridge, bridge, autozero temp, temp, then correction.
// - full measurement leaves corrected bridge then corrected temperature words.
// - Fx is a no-operation keeping status and last data; host uses SPI only.
// - raw A0..A7: lsb clear uses stored setup, set uses host word.
// - A0/A1 bridge, A2/A3 az bridge, A4/A5 temp, A6/A7 az temp.
// - stored setup: bridge uses bridge setup word, temp uses temp register.
// - host word for raw temperature ignores bits 15 down to 13.
// - command mode entered only if A9 is the first command after reset.
// - normal mode goes back to sleep after the measurement.
// - raw command puts the 16-bit converter result, less the autozero sample for A2/A3/A6/A7, in the first output word.
// - status reports mode: 00 normal, 01 command.
module scd_decoder
    import scd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [15:0] cmd_word,
    input wire logic [15:0] bridge_frontend_setup,
    input wire logic [15:0] temp_setup,
    input wire logic csum_present,
    input wire logic csum_done,
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    input wire logic calc_done,
    input wire scd_result_t calc_result,
    output logic conv_start,
    output scd_conv_req_t conv_req,
    output logic calc_start,
    output scd_calc_req_t calc_req,
    output logic csum_start,
    output logic [7:0] status_byte,
    output scd_result_t data_out,
    output logic data_ready,
    output logic eoc,
    output logic lv_active
);
    scd_state_t state_reg, state_next;
    logic [1:0] mode_reg, mode_next;
    logic first_cmd_reg;
    logic full_reg;
    logic use_host_reg;
    logic [15:0] host_word_reg;
    logic [1:0] cur_step_reg, first_step_reg, last_step_reg;
    logic [15:0] sample_reg [4];
    logic conv_start_reg, calc_start_reg, csum_start_reg;
    scd_conv_req_t conv_req_reg;
    logic [7:0] status_reg;
    scd_result_t data_reg;
    logic data_ready_reg, eoc_reg, lv_active_reg;

    // decode; nothing is taken while busy, the host polls status first
    wire idle = (state_reg == SCD_IDLE);
    wire take = cmd_valid && idle;
    wire is_nop = (cmd_byte[7:4] == SCD_CMD_NOP_NIBBLE);
    wire is_raw = (cmd_byte[7:3] == SCD_CMD_RAW_TOP);
    wire is_norm = (cmd_byte == SCD_CMD_GO_NORMAL);
    wire is_cmdm = (cmd_byte == SCD_CMD_GO_COMMAND);
    wire is_csum = (cmd_byte == SCD_CMD_COMMIT_CSUM);
    wire is_full = (cmd_byte == SCD_CMD_FULL_MEAS);
    wire in_cmd = (mode_reg == SCD_MODE_COMMAND);
    wire do_norm = take && is_norm && in_cmd;
    wire do_cmdm = take && is_cmdm && !in_cmd && first_cmd_reg;
    wire do_csum = take && is_csum && in_cmd && !csum_present;
    wire do_meas = take && (is_full || is_raw);
    // raw step span from code bits 2:1
    wire [1:0] raw_first = {cmd_byte[2], ~cmd_byte[1]};
    wire [1:0] raw_last = {cmd_byte[2], 1'b1};
    wire [1:0] new_first = is_full ? 2'(SCD_STEP_AZ_BRIDGE) : raw_first;
    wire [1:0] new_last = is_full ? 2'(SCD_STEP_TEMP) : raw_last;
    wire new_host = is_raw && cmd_byte[0];

    // setup for a step; temperature host words keep stored bits 15:13
    function automatic logic [15:0] pick_setup(input logic [1:0] step, input logic host,
                                               input logic [15:0] word);
        logic [15:0] s;
        s = 16'h0000;
        if (!step[1]) begin
            s = host ? word : bridge_frontend_setup;
        end else begin
            s = host ? {temp_setup[15:SCD_TEMP_DROP_LSB], word[SCD_TEMP_KEEP_MSB:0]} : temp_setup;
        end
        return s;
    endfunction : pick_setup

    wire step_end = (state_reg == SCD_CONV) && conv_done;
    wire last_step = (cur_step_reg == last_step_reg);
    wire [1:0] step_inc = 2'(cur_step_reg + 2'h1);
    // autozero corrected raw result subtracts the preceding autozero sample
    wire [15:0] raw_val = (first_step_reg != last_step_reg) ?
                          16'(conv_result - sample_reg[first_step_reg]) : conv_result;
    wire raw_done = step_end && last_step && !full_reg;
    wire calc_end = (state_reg == SCD_CALC) && calc_done;
    wire csum_end = (state_reg == SCD_CSUM) && csum_done;
    wire issue_first = do_meas;
    wire issue_next = step_end && !last_step;
    wire [1:0] issue_step = issue_first ? new_first : step_inc;
    wire issue_host = issue_first ? new_host : use_host_reg;
    wire [15:0] issue_word = issue_first ? cmd_word : host_word_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCD_IDLE: begin
                if (do_meas) begin
                    state_next = SCD_CONV;
                end else if (do_csum) begin
                    state_next = SCD_CSUM;
                end
            end
            SCD_CONV: begin
                if (step_end && last_step) begin
                    state_next = full_reg ? SCD_CALC : SCD_IDLE;
                end
            end
            SCD_CALC: begin
                if (calc_done) begin
                    state_next = SCD_IDLE;
                end
            end
            SCD_CSUM: begin
                if (csum_done) begin
                    state_next = SCD_IDLE;
                end
            end
            default: state_next = SCD_IDLE;
        endcase
    end

    assign mode_next = do_norm ? SCD_MODE_NORMAL : (do_cmdm ? SCD_MODE_COMMAND : mode_reg);
    wire busy_next = (state_next != SCD_IDLE);
    // mode and busy in the status byte; error flags belong to the memory logic
    wire [7:0] status_next = SCD_STATUS_RST | ({6'h00, mode_next} << SCD_ST_MODE_LO) |
                             ({7'h00, busy_next} << SCD_ST_BUSY);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SCD_IDLE;
            mode_reg <= SCD_MODE_NORMAL;
            first_cmd_reg <= 1'b1;
            status_reg <= SCD_STATUS_RST;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            status_reg <= status_next;
            if (take) begin
                first_cmd_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            full_reg <= 1'b0;
            use_host_reg <= 1'b0;
            host_word_reg <= SCD_WORD_RST;
            first_step_reg <= 2'h0;
            last_step_reg <= 2'h0;
            cur_step_reg <= 2'h0;
        end else begin
            if (do_meas) begin
                full_reg <= is_full;
                use_host_reg <= new_host;
                host_word_reg <= cmd_word;
                first_step_reg <= new_first;
                last_step_reg <= new_last;
            end
            if (issue_first || issue_next) begin
                cur_step_reg <= issue_step;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (step_end) begin
            sample_reg[cur_step_reg] <= conv_result;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_start_reg <= 1'b0;
            conv_req_reg <= '0;
            calc_start_reg <= 1'b0;
            csum_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= issue_first || issue_next;
            calc_start_reg <= step_end && last_step && full_reg;
            csum_start_reg <= do_csum;
            if (issue_first || issue_next) begin
                conv_req_reg <= '{step: scd_step_t'(issue_step),
                                  setup: pick_setup(issue_step, issue_host, issue_word)};
            end
        end
    end

    // any new command other than a no-operation invalidates the last data,
    // but the words themselves stay until replaced
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_reg <= '0;
            data_ready_reg <= 1'b0;
            eoc_reg <= 1'b0;
            lv_active_reg <= 1'b0;
        end else begin
            if (calc_end) begin
                data_reg <= calc_result;
            end else if (raw_done) begin
                data_reg <= '{first: raw_val, second: SCD_WORD_RST};
            end
            if (calc_end || raw_done) begin
                data_ready_reg <= 1'b1;
            end else if (take && !is_nop) begin
                data_ready_reg <= 1'b0;
            end
            if (calc_end || raw_done) begin
                eoc_reg <= 1'b1;
            end else if (do_meas) begin
                eoc_reg <= 1'b0;
            end
            // sleeps again in normal mode once idle
            lv_active_reg <= busy_next || (mode_next == SCD_MODE_COMMAND);
        end
    end

    assign conv_start = conv_start_reg;
    assign conv_req = conv_req_reg;
    assign calc_start = calc_start_reg;
    assign calc_req = '{az_bridge: sample_reg[0], bridge: sample_reg[1],
                        az_temp: sample_reg[2], temp: sample_reg[3]};
    assign csum_start = csum_start_reg;
    assign status_byte = status_reg;
    assign data_out = data_reg;
    assign data_ready = data_ready_reg;
    assign eoc = eoc_reg;
    assign lv_active = lv_active_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_go_normal_mode: assert property (take && is_norm |=> mode_reg == SCD_MODE_NORMAL)
        else $error("A8 did not leave normal mode set");
    a_go_command_mode: assert property (take && is_cmdm && !in_cmd && first_cmd_reg
                                        |=> mode_reg == SCD_MODE_COMMAND)
        else $error("A9 as first command did not enter command mode");
    a_late_go_command: assert property (take && is_cmdm && !first_cmd_reg |=> $stable(mode_reg))
        else $error("late A9 changed mode");
    a_commit_gate: assert property (take && is_csum
                                    |=> csum_start == ($past(in_cmd) && !$past(csum_present)))
        else $error("checksum start does not follow mode and page state");
    a_refused_quiet: assert property (take && is_csum && !in_cmd |=> state_reg == SCD_IDLE && !conv_start)
        else $error("refused command started work");
    a_full_sequence: assert property (take && is_full |=> conv_start && conv_req.step == SCD_STEP_AZ_BRIDGE)
        else $error("full measurement did not start with autozero bridge");
    a_step_advance: assert property (step_end && !last_step
                                     |=> conv_start && conv_req.step == scd_step_t'(2'($past(cur_step_reg) + 2'h1)))
        else $error("measurement steps out of order");
    a_raw_first_step: assert property (take && is_raw
                                       |=> conv_req.step == scd_step_t'({$past(cmd_byte[2]), ~$past(cmd_byte[1])}))
        else $error("raw command chose wrong conversion");
    a_raw_temp_setup: assert property (conv_start && use_host_reg && conv_req.step[1]
                                       |-> conv_req.setup == {temp_setup[15:13], host_word_reg[12:0]})
        else $error("host temperature setup not masked");
    a_stored_setup: assert property (conv_start && !use_host_reg
                                     |-> conv_req.setup == (conv_req.step[1] ? temp_setup : bridge_frontend_setup))
        else $error("stored setup not used");
    a_full_result: assert property (calc_end |=> data_out == $past(calc_result) && data_ready)
        else $error("corrected words not stored");
    a_raw_result: assert property (raw_done && first_step_reg == last_step_reg
                                   |=> data_out.first == $past(conv_result) && eoc)
        else $error("raw result not stored");
    a_nop_keeps_data: assert property (take && is_nop |=> $stable(data_out) && $stable(mode_reg))
        else $error("no-operation changed data or mode");
    a_status_mode: assert property (status_byte[SCD_ST_MODE_HI:SCD_ST_MODE_LO] == mode_reg)
        else $error("status mode bits disagree with mode");
    a_busy_holds: assert property (state_reg == SCD_CONV && !conv_done
                                   |=> $stable(data_out) && status_byte[SCD_ST_BUSY])
        else $error("data changed or busy dropped during measurement");
    a_sleep_after: assert property ($fell(status_byte[SCD_ST_BUSY]) && mode_reg == SCD_MODE_NORMAL
                                    |-> !lv_active)
        else $error("normal mode stayed awake after measurement");

    c_full_cycle: cover property (calc_end);
    c_enter_command: cover property (do_cmdm);
    c_az_raw_host: cover property (raw_done && use_host_reg && first_step_reg != last_step_reg);
    c_commit: cover property (csum_end);
endmodule : scd_decoder

// File: verification/scd_engine_model.sv
// behavioural converter, correction unit and checksum store behind the decoder
`timescale 1ns/1ps
module scd_engine_model
    import scd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] lat,
    input wire logic conv_start,
    input wire scd_conv_req_t conv_req,
    input wire logic calc_start,
    input wire scd_calc_req_t calc_req,
    input wire logic csum_start,
    output logic conv_done,
    output logic [15:0] conv_result,
    output logic calc_done,
    output scd_result_t calc_result,
    output logic csum_done
);
    logic pend_reg;
    logic done_reg;
    logic [1:0] kind_reg;
    logic [7:0] cnt_reg;
    logic [31:0] val_reg;
    assign conv_done = done_reg && kind_reg == 2'h0;
    assign calc_done = done_reg && kind_reg == 2'h1;
    assign csum_done = done_reg && kind_reg == 2'h2;
    // outside the done cycle results are inverted so a late sample reads wrong data
    assign conv_result = conv_done ? val_reg[15:0] : ~val_reg[15:0];
    assign calc_result = calc_done ? val_reg : ~val_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
            done_reg <= 1'b0;
            kind_reg <= 2'h3;
            cnt_reg <= 8'h00;
            val_reg <= 32'h0000_0000;
        end else begin
            done_reg <= pend_reg && cnt_reg == 8'h00;
            if (pend_reg && cnt_reg == 8'h00) begin
                pend_reg <= 1'b0;
            end else if (pend_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
            if (conv_start || calc_start || csum_start) begin
                pend_reg <= 1'b1;
                cnt_reg <= lat;
                kind_reg <= conv_start ? 2'h0 : (calc_start ? 2'h1 : 2'h2);
                val_reg <= conv_start ? {16'h0000, conv_req.setup ^ {8{conv_req[17:16]}}}
                    : {calc_req.bridge - calc_req.az_bridge, calc_req.temp - calc_req.az_temp};
            end
        end
    end
endmodule : scd_engine_model

// File: verification/sensor_cmd_decoder_tb_top.sv
// self-checking bench for the sensor command decoder
`timescale 1ns/1ps
module sensor_cmd_decoder_tb_top;
    import scd_pkg::*;
    logic clk, nrst, cmd_valid, csum_present;
    logic [7:0] cmd_byte, lat, status_byte;
    logic [15:0] cmd_word, bridge_frontend_setup, temp_setup, conv_result;
    logic conv_done, calc_done, csum_done, conv_start, calc_start, csum_start;
    logic data_ready, eoc, lv_active;
    scd_result_t calc_result, data_out;
    scd_conv_req_t conv_req;
    scd_calc_req_t calc_req;
    int n_errors, num_checks, n_csum;
    scd_conv_req_t issued[$];

    scd_decoder dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_word(cmd_word),
        .bridge_frontend_setup(bridge_frontend_setup), .temp_setup(temp_setup), .csum_present(csum_present),
        .csum_done(csum_done), .conv_done(conv_done), .conv_result(conv_result), .calc_done(calc_done),
        .calc_result(calc_result), .conv_start(conv_start), .conv_req(conv_req), .calc_start(calc_start),
        .calc_req(calc_req), .csum_start(csum_start), .status_byte(status_byte), .data_out(data_out),
        .data_ready(data_ready), .eoc(eoc), .lv_active(lv_active));
    scd_engine_model eng (.clk(clk), .nrst(nrst), .lat(lat), .conv_start(conv_start), .conv_req(conv_req),
        .calc_start(calc_start), .calc_req(calc_req), .csum_start(csum_start), .conv_done(conv_done),
        .conv_result(conv_result), .calc_done(calc_done), .calc_result(calc_result), .csum_done(csum_done));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (conv_start === 1'b1) issued.push_back(conv_req);
        if (csum_start === 1'b1) n_csum++;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic check_val(input logic [39:0] got, input logic [39:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_val

    function automatic logic [7:0] st(input logic busy, input logic [1:0] mode);
        return {2'b01, busy, mode, 3'b000};
    endfunction : st

    function automatic logic [15:0] conv_of(input logic [1:0] step, input logic [15:0] setup);
        return setup ^ {8{step}};
    endfunction : conv_of

    task automatic send(input logic [7:0] code, input logic [15:0] word);
        @(posedge clk);
        #2;
        cmd_valid = 1'b1;
        cmd_byte = code;
        cmd_word = word;
        @(posedge clk);
        #2;
        cmd_valid = 1'b0;
        cmd_word = ~word;
    endtask : send

    task automatic wait_idle();
        for (int i = 0; i < 3000; i++) begin
            if (status_byte[SCD_ST_BUSY] === 1'b0) return;
            @(posedge clk);
            #2;
        end
        n_errors++;
        $display("wrong value at %0t: busy stuck", $time);
        print_verdict();
    endtask : wait_idle

    task automatic do_reset();
        nrst = 1'b0;
        repeat (16) @(posedge clk);
        #2;
        nrst = 1'b1;
        issued.delete();
        check_val(status_byte, st(0, SCD_MODE_NORMAL), "reset status");
        check_val({data_ready, eoc, lv_active}, 3'b000, "reset flags");
    endtask : do_reset

    task automatic t_modes();
        send(SCD_CMD_GO_COMMAND, 16'h0000); // host opens with the mode switch
        check_val({status_byte, lv_active}, {st(0, SCD_MODE_COMMAND), 1'b1}, "enter cmd");
        send(SCD_CMD_GO_COMMAND, 16'h0000);
        check_val(status_byte, st(0, SCD_MODE_COMMAND), "repeat cmd");
        csum_present = 1'b1;
        send(SCD_CMD_COMMIT_CSUM, 16'h0000);
        check_val({csum_start, status_byte}, {1'b0, st(0, SCD_MODE_COMMAND)}, "csum present");
        csum_present = 1'b0;
        send(SCD_CMD_COMMIT_CSUM, 16'h0000);
        check_val(status_byte, st(1, SCD_MODE_COMMAND), "csum busy");
        wait_idle();
        check_val(n_csum, 1, "csum starts");
        send(SCD_CMD_GO_NORMAL, 16'h0000);
        check_val({status_byte, lv_active}, {st(0, SCD_MODE_NORMAL), 1'b0}, "leave cmd");
        send(SCD_CMD_GO_NORMAL, 16'h0000);
        check_val(status_byte, st(0, SCD_MODE_NORMAL), "repeat normal");
        send(SCD_CMD_COMMIT_CSUM, 16'h0000);
        check_val({csum_start, status_byte}, {1'b0, st(0, SCD_MODE_NORMAL)}, "csum in normal");
        send(SCD_CMD_GO_COMMAND, 16'h0000);
        check_val(status_byte, st(0, SCD_MODE_NORMAL), "late go cmd");
    endtask : t_modes

    task automatic t_raw(input logic [7:0] code, input logic [15:0] word, input logic [1:0] mode);
        logic temp;
        logic az;
        logic [15:0] setup;
        logic [15:0] exp;
        scd_result_t old;
        temp = code[2];
        az = code[1];
        setup = code[0] ? word : (temp ? temp_setup : bridge_frontend_setup);
        if (code[0] && temp) setup[15:13] = temp_setup[15:13];
        exp = conv_of({temp, 1'b1}, setup) - (az ? conv_of({temp, 1'b0}, setup) : 16'h0000);
        old = data_out;
        issued.delete();
        send(code, word);
        check_val(data_out, old, "raw hold");
        check_val({data_ready, status_byte}, {1'b0, st(1, mode)}, "raw taken");
        // refused while busy: mode must not move
        send(SCD_CMD_GO_NORMAL, 16'h0000);
        wait_idle();
        check_val(data_out, {exp, 16'h0000}, "raw result");
        check_val({data_ready, eoc, status_byte[4:3], lv_active}, {2'b11, mode, mode[0]}, "raw done");
        check_val(issued.size(), az ? 2 : 1, "conv count");
        check_val(issued[0], {temp, ~az, setup}, "first setup");
        check_val(issued[issued.size() - 1], {temp, 1'b1, setup}, "main setup");
    endtask : t_raw

    task automatic t_nop(input logic [7:0] code);
        scd_result_t old;
        old = data_out;
        send(code, 16'h0000); // status poll used over the serial peripheral link only
        check_val({data_ready, status_byte[SCD_ST_BUSY], data_out}, {2'b10, old}, "nop keeps");
    endtask : t_nop

    task automatic t_full(input logic [1:0] mode);
        scd_result_t old;
        logic [15:0] b;
        logic [15:0] t;
        b = bridge_frontend_setup;
        t = temp_setup;
        old = data_out;
        issued.delete();
        send(SCD_CMD_FULL_MEAS, 16'h0000);
        check_val({data_out, status_byte[SCD_ST_BUSY]}, {old, 1'b1}, "full hold");
        wait_idle();
        check_val(issued.size(), 4, "full steps");
        for (int i = 0; i < 4 && i < issued.size(); i++) begin
            check_val(issued[i], {i[1:0], (i < 2) ? b : t}, "step order");
        end
        check_val(data_out, {conv_of(1, b) - conv_of(0, b), conv_of(3, t) - conv_of(2, t)}, "full data");
        check_val({data_ready, eoc, status_byte[4:3], lv_active}, {2'b11, mode, mode[0]}, "full done");
    endtask : t_full

    task automatic t_late_first();
        send(8'hf5, 16'h0000); // a poll already counts as the first command
        send(SCD_CMD_GO_COMMAND, 16'h0000);
        check_val({status_byte, lv_active}, {st(0, SCD_MODE_NORMAL), 1'b0}, "not first");
    endtask : t_late_first

    initial begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        cmd_word = 16'h0000;
        bridge_frontend_setup = 16'h5a3c;
        temp_setup = 16'hc3e1;
        csum_present = 1'b0;
        lat = 8'h00;
        n_errors = 0;
        num_checks = 0;
        n_csum = 0;
        do_reset();
        t_modes();
        for (int c = 0; c < 8; c++) begin
            t_raw(8'ha0 + c[7:0], c[0] ? 16'hf7a5 : 16'h0000, SCD_MODE_NORMAL); // even codes carry zero
        end
        t_nop(8'hf0);
        t_nop(8'hfb);
        lat = 8'h07;
        t_full(SCD_MODE_NORMAL);
        do_reset();
        t_late_first();
        do_reset();
        send(SCD_CMD_GO_COMMAND, 16'h0000);
        t_raw(8'ha6, 16'h0000, SCD_MODE_COMMAND); // autozero with stored setup for calibration
        t_raw(8'ha3, 16'h1234, SCD_MODE_COMMAND);
        t_full(SCD_MODE_COMMAND);
        t_nop(8'hff);
        print_verdict();
    end
endmodule : sensor_cmd_decoder_tb_top
